/* src/burst_master.sv */
/*
  Master end of a five-channel burst bus: takes user commands, issues read
  and write addresses, streams write beats with strobes, and returns read
  beats and write completions to the user through register slices.
  Assumes the slave follows the valid/ready handshake on every channel.
*/
`timescale 1ns/10ps
`include "burst_master_regs.svh"
module burst_master
  import burst_master_pkg::*;
(
  input wire logic sys_clk, // Clock, 250 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic cmd_valid, // User command offered.
  output logic cmd_ready, // Command taken when high with valid.
  input wire logic cmd_write, // 1 write, 0 read.
  input wire burst_master_pkg::id_t cmd_id, // Transaction tag.
  input wire burst_master_pkg::addr_t cmd_addr, // Burst start address.
  input wire burst_master_pkg::len_t cmd_len, // Beats minus one.
  input wire logic ud_valid, // User write beat offered.
  output logic ud_ready, // Write beat taken when high with valid.
  input wire burst_master_pkg::data_t ud_data, // User write beat.
  output logic rd_valid, // Read beat for the user.
  input wire logic rd_ready, // User accepts read beat.
  output burst_master_pkg::data_t rd_data, // Read beat data.
  output burst_master_pkg::id_t rd_id, // Read beat tag.
  output burst_master_pkg::resp_t rd_resp, // Read beat status.
  output logic rd_last, // Final beat of a read burst.
  output logic wd_valid, // Write completion for the user.
  input wire logic wd_ready, // User accepts completion.
  output burst_master_pkg::id_t wd_id, // Completed write tag.
  output burst_master_pkg::resp_t wd_resp, // Completed write status.
  output logic bus_resetn, // Bus reset, active low.
  output burst_master_pkg::id_t awid, // Write address tag.
  output burst_master_pkg::addr_t awaddr, // Write start address.
  output burst_master_pkg::len_t awlen, // Write beats minus one.
  output logic [2:0] awsize, // Bytes per beat, log2.
  output logic [1:0] awburst, // Burst type.
  output logic awvalid, // Write address valid.
  input wire logic awready, // Write address ready.
  output burst_master_pkg::data_t wdata, // Write beat data.
  output burst_master_pkg::strb_t wstrb, // Write byte lanes.
  output logic wlast, // Last write beat.
  output logic wvalid, // Write beat valid.
  input wire logic wready, // Write beat ready.
  input wire burst_master_pkg::id_t bid, // Response tag.
  input wire burst_master_pkg::resp_t bresp, // Response status.
  input wire logic bvalid, // Response valid.
  output logic bready, // Response ready.
  output burst_master_pkg::id_t arid, // Read address tag.
  output burst_master_pkg::addr_t araddr, // Read start address.
  output burst_master_pkg::len_t arlen, // Read beats minus one.
  output logic [2:0] arsize, // Bytes per beat, log2.
  output logic [1:0] arburst, // Burst type.
  output logic arvalid, // Read address valid.
  input wire logic arready, // Read address ready.
  input wire burst_master_pkg::id_t rid, // Read beat tag.
  input wire burst_master_pkg::data_t rdata, // Read beat data.
  input wire burst_master_pkg::resp_t rresp, // Read beat status.
  input wire logic rlast, // Last read beat.
  input wire logic rvalid, // Read beat valid.
  output logic rready // Read beat ready.
);
  localparam int RW = `ID_W + `DATA_W + `RESP_W + 1;
  localparam int BW = `ID_W + `RESP_W;

  function automatic cnt_t step(cnt_t c, logic up, logic dn);
    step = cnt_t'(c + cnt_t'(up) - cnt_t'(dn));
  endfunction

  function automatic logic [`PTR_W-1:0] ptr_inc(logic [`PTR_W-1:0] p);
    ptr_inc = p + 2'h1;
  endfunction

  // ----------------------------------------------------------------
  // Address issue
  // ----------------------------------------------------------------
  id_t awid_r, awid_nxt, arid_r, arid_nxt;
  addr_t awaddr_r, awaddr_nxt, araddr_r, araddr_nxt;
  len_t awlen_r, awlen_nxt, arlen_r, arlen_nxt;
  logic awvalid_r, awvalid_nxt, arvalid_r, arvalid_nxt;
  logic cmd_ready_r, cmd_ready_nxt, resetn_r;
  cnt_t wr_out_r, wr_out_nxt, rd_out_r, rd_out_nxt;
  logic acc_w, acc_r, b_hs, r_end;

  assign acc_w = cmd_valid && cmd_ready_r && cmd_write;
  assign acc_r = cmd_valid && cmd_ready_r && !cmd_write;
  assign b_hs = bvalid && bready;
  assign r_end = rvalid && rready && rlast;

  always_comb begin
    awid_nxt = awid_r;
    awaddr_nxt = awaddr_r;
    awlen_nxt = awlen_r;
    arid_nxt = arid_r;
    araddr_nxt = araddr_r;
    arlen_nxt = arlen_r;
    awvalid_nxt = awvalid_r && !awready;
    arvalid_nxt = arvalid_r && !arready;
    // only the start address is sent
    if (acc_w) begin
      awid_nxt = cmd_id;
      awaddr_nxt = cmd_addr;
      awlen_nxt = cmd_len;
      awvalid_nxt = 1'b1;
    end
    if (acc_r) begin
      arid_nxt = cmd_id;
      araddr_nxt = cmd_addr;
      arlen_nxt = cmd_len;
      arvalid_nxt = 1'b1;
    end
    // several bursts outstanding, up to the limit
    wr_out_nxt = step(wr_out_r, acc_w, b_hs);
    rd_out_nxt = step(rd_out_r, acc_r, r_end);
    cmd_ready_nxt = !(acc_w || acc_r) && !awvalid_nxt && !arvalid_nxt &&
                    (wr_out_nxt < `MAX_OUT) && (rd_out_nxt < `MAX_OUT);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awid_r <= '0;
      awaddr_r <= '0;
      awlen_r <= '0;
      arid_r <= '0;
      araddr_r <= '0;
      arlen_r <= '0;
      awvalid_r <= 1'b0;
      arvalid_r <= 1'b0;
      cmd_ready_r <= 1'b0;
      wr_out_r <= '0;
      rd_out_r <= '0;
      resetn_r <= 1'b0;
    end else begin
      awid_r <= awid_nxt;
      awaddr_r <= awaddr_nxt;
      awlen_r <= awlen_nxt;
      arid_r <= arid_nxt;
      araddr_r <= araddr_nxt;
      arlen_r <= arlen_nxt;
      awvalid_r <= awvalid_nxt;
      arvalid_r <= arvalid_nxt;
      cmd_ready_r <= cmd_ready_nxt;
      wr_out_r <= wr_out_nxt;
      rd_out_r <= rd_out_nxt;
      // bus reset low while reset holds
      resetn_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write data
  // ----------------------------------------------------------------
  // Pending write bursts queue here, four deep, so that data may follow its
  // address by up to four bursts; the beat register costs one idle cycle per beat.
  len_t wq_len_r [4];
  logic [`PTR_W-1:0] wq_off_r [4];
  logic [`PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  cnt_t wq_cnt_r, wq_cnt_nxt;
  len_t beat_r, beat_nxt;
  data_t wdata_r, wdata_nxt;
  strb_t wstrb_r, wstrb_nxt, lane;
  logic wlast_r, wlast_nxt, wvalid_r, wvalid_nxt, ud_ready_r, ud_ready_nxt;
  logic take, pop;

  strobe_gen u_strb (
    .offset(wq_off_r[rp_r]),
    .first(beat_r == '0),
    .strb(lane)
  );

  assign take = ud_valid && ud_ready_r;
  assign pop = take && (beat_r == wq_len_r[rp_r]);

  always_comb begin
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    wlast_nxt = wlast_r;
    wvalid_nxt = wvalid_r && !wready;
    beat_nxt = beat_r;
    // data may run ahead of write completions
    wp_nxt = acc_w ? ptr_inc(wp_r) : wp_r;
    rp_nxt = pop ? ptr_inc(rp_r) : rp_r;
    wq_cnt_nxt = step(wq_cnt_r, acc_w, pop);
    if (take) begin
      wdata_nxt = ud_data;
      wstrb_nxt = lane;
      wlast_nxt = pop;
      wvalid_nxt = 1'b1;
      beat_nxt = pop ? len_t'(0) : len_t'(beat_r + 8'h01);
    end
    ud_ready_nxt = !take && !wvalid_nxt && (wq_cnt_nxt != '0);
  end

  always_ff @(posedge sys_clk) begin
    if (acc_w) begin
      wq_len_r[wp_r] <= cmd_len;
      wq_off_r[wp_r] <= cmd_addr[`PTR_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      wq_cnt_r <= '0;
      beat_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      wlast_r <= 1'b0;
      wvalid_r <= 1'b0;
      ud_ready_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      wq_cnt_r <= wq_cnt_nxt;
      beat_r <= beat_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      wlast_r <= wlast_nxt;
      wvalid_r <= wvalid_nxt;
      ud_ready_r <= ud_ready_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data and write responses
  // ----------------------------------------------------------------
  // status travels with beat
  // tags pass through so out-of-order returns stay attributable
  reg_slice #(.W(RW)) u_rslice (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(rvalid),
    .in_ready(rready),
    .in_data({rid, rdata, rresp, rlast}),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data({rd_id, rd_data, rd_resp, rd_last})
  );

  reg_slice #(.W(BW)) u_bslice (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(bvalid),
    .in_ready(bready),
    .in_data({bid, bresp}),
    .out_valid(wd_valid),
    .out_ready(wd_ready),
    .out_data({wd_id, wd_resp})
  );

  assign cmd_ready = cmd_ready_r;
  assign ud_ready = ud_ready_r;
  assign bus_resetn = resetn_r;
  assign awid = awid_r;
  assign awaddr = awaddr_r;
  assign awlen = awlen_r;
  assign awsize = `SIZE_FULL;
  assign awburst = `BURST_INCR;
  assign awvalid = awvalid_r;
  assign wdata = wdata_r;
  assign wstrb = wstrb_r;
  assign wlast = wlast_r;
  assign wvalid = wvalid_r;
  assign arid = arid_r;
  assign araddr = araddr_r;
  assign arlen = arlen_r;
  assign arsize = `SIZE_FULL;
  assign arburst = `BURST_INCR;
  assign arvalid = arvalid_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_aw_stall;
    awvalid && !awready;
  endsequence
  sequence s_w_stall;
    wvalid && !wready;
  endsequence

  property p_aw_hold;
    s_aw_stall |=> awvalid && $stable(awaddr) && $stable(awlen);
  endproperty
  a_aw_hold: assert property (p_aw_hold)
    else $error("write address dropped before handshake");

  property p_ar_hold;
    arvalid && !arready |=> arvalid && $stable(araddr) && $stable(arid);
  endproperty
  a_ar_hold: assert property (p_ar_hold)
    else $error("read address dropped before handshake");

  property p_w_hold;
    s_w_stall |=> wvalid && $stable(wdata) && $stable(wstrb) && $stable(wlast);
  endproperty
  a_w_hold: assert property (p_w_hold)
    else $error("write beat changed while stalled");

  property p_cmd_aw;
    acc_w |=> awvalid && awaddr == $past(cmd_addr) && awlen == $past(cmd_len);
  endproperty
  a_cmd_aw: assert property (p_cmd_aw)
    else $error("write command not issued as start address");

  property p_cmd_ar;
    acc_r |=> arvalid && arid == $past(cmd_id);
  endproperty
  a_cmd_ar: assert property (p_cmd_ar)
    else $error("read command not issued");

  property p_out_limit;
    wr_out_r <= `MAX_OUT && rd_out_r <= `MAX_OUT && wq_cnt_r <= wr_out_r;
  endproperty
  a_out_limit: assert property (p_out_limit)
    else $error("outstanding count out of range");

  property p_first_strb;
    take && beat_r == '0 |=> wstrb == strb_t'(`STRB_ALL << $past(wq_off_r[rp_r]));
  endproperty
  a_first_strb: assert property (p_first_strb)
    else $error("first beat strobe wrong");

  property p_last_pop;
    pop |=> wlast && wvalid && wq_cnt_r == $past(step(wq_cnt_r, acc_w, 1'b1));
  endproperty
  a_last_pop: assert property (p_last_pop)
    else $error("burst end not marked or not retired");

  property p_resetn;
    $fell(rst) |-> !bus_resetn ##1 bus_resetn;
  endproperty
  a_resetn: assert property (@(posedge sys_clk) p_resetn)
    else $error("bus reset not active low");
endmodule

/* src/burst_master_pkg.sv */
/*
  Types shared by the burst bus master and its helper modules.
  Assumes burst_master_regs.svh is on the include path.
*/
`include "burst_master_regs.svh"
package burst_master_pkg;
  typedef logic [`ID_W-1:0] id_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`STRB_W-1:0] strb_t;
  typedef logic [`LEN_W-1:0] len_t;
  typedef logic [`RESP_W-1:0] resp_t;
  typedef logic [`OUT_W-1:0] cnt_t;
endpackage

/* src/burst_master_regs.svh */
/*
  Constants for the five-channel burst bus master: widths, encodings, limits.
  Assumes it is included once per compilation unit through its guard.
*/
`ifndef BURST_MASTER_REGS_SVH
`define BURST_MASTER_REGS_SVH
`define DATA_W 32
`define STRB_W 4
`define ADDR_W 32
`define ID_W 4
`define LEN_W 8
`define RESP_W 2
`define OUT_W 3
`define MAX_OUT 3'h4
`define PTR_W 2
`define SIZE_FULL 3'h2
`define BURST_INCR 2'h1
`define STRB_ALL 4'hf
`endif

/* src/reg_slice.sv */
/*
  Two-entry register slice for one handshaked channel, all outputs from flops.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module reg_slice #(
  parameter int W = 8
) (
  input wire logic sys_clk, // Clock.
  input wire logic rst, // Synchronous reset.
  input wire logic in_valid, // Upstream valid.
  output logic in_ready, // Upstream ready, registered.
  input wire logic [W-1:0] in_data, // Upstream payload.
  output logic out_valid, // Downstream valid, registered.
  input wire logic out_ready, // Downstream ready.
  output logic [W-1:0] out_data // Downstream payload, registered.
);
  logic [W-1:0] main_r, main_nxt, skid_r, skid_nxt;
  logic mv_r, mv_nxt, sv_r, sv_nxt, rdy_r, rdy_nxt;

  always_comb begin
    main_nxt = main_r;
    skid_nxt = skid_r;
    mv_nxt = mv_r;
    sv_nxt = sv_r;
    if (mv_r && out_ready) begin
      if (sv_r) begin
        main_nxt = skid_r;
        sv_nxt = 1'b0;
      end else begin
        mv_nxt = 1'b0;
      end
    end
    if (in_valid && rdy_r) begin
      if (!mv_nxt) begin
        main_nxt = in_data;
        mv_nxt = 1'b1;
      end else begin
        skid_nxt = in_data;
        sv_nxt = 1'b1;
      end
    end
    rdy_nxt = !sv_nxt;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mv_r <= 1'b0;
      sv_r <= 1'b0;
      rdy_r <= 1'b0;
      main_r <= '0;
      skid_r <= '0;
    end else begin
      mv_r <= mv_nxt;
      sv_r <= sv_nxt;
      rdy_r <= rdy_nxt;
      main_r <= main_nxt;
      skid_r <= skid_nxt;
    end
  end

  assign in_ready = rdy_r;
  assign out_valid = mv_r;
  assign out_data = main_r;

  property p_slice_hold;
    @(posedge sys_clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_slice_hold: assert property (p_slice_hold)
    else $error("slice output changed while stalled");
endmodule

/* src/strobe_gen.sv */
/*
  Byte-lane strobe for one write beat: lanes below the start offset are off
  on the first beat of a burst, all lanes are on afterwards.
  Assumes bursts use the full bus width per beat.
*/
`timescale 1ns/10ps
`include "burst_master_regs.svh"
module strobe_gen
  import burst_master_pkg::*;
(
  input wire logic [`PTR_W-1:0] offset, // Byte offset of the burst start.
  input wire logic first, // High on the first beat of a burst.
  output burst_master_pkg::strb_t strb // One bit per byte lane.
);
  always_comb begin
    if (first) begin
      strb = strb_t'(`STRB_ALL << offset);
    end else begin
      strb = `STRB_ALL;
    end
  end
endmodule

/* verif/burst_slave_model.sv */
/*
  Behavioural slave for the burst master bench: a word memory, a status with
  every read beat and one completion per write burst.
  Assumes full-width incrementing bursts and a single clock.
*/
`timescale 1ns/10ps
module burst_slave_model
  import burst_master_pkg::*;
(
  input wire logic sys_clk, // Clock.
  input wire logic rst, // Reset, active high.
  input wire logic slow, // Stall on alternate cycles, on alternate cycle pairs for AR and R.
  input wire logic ooo, // Let a later read overtake.
  input wire burst_master_pkg::id_t awid, // AW tag.
  input wire burst_master_pkg::addr_t awaddr, // AW address.
  input wire logic awvalid, // AW valid.
  output logic awready, // AW ready.
  input wire burst_master_pkg::data_t wdata, // W data.
  input wire burst_master_pkg::strb_t wstrb, // W lanes.
  input wire logic wlast, // W last.
  input wire logic wvalid, // W valid.
  output logic wready, // W ready.
  output burst_master_pkg::id_t bid, // B tag.
  output burst_master_pkg::resp_t bresp, // B status.
  output logic bvalid, // B valid.
  input wire logic bready, // B ready.
  input wire burst_master_pkg::id_t arid, // AR tag.
  input wire burst_master_pkg::addr_t araddr, // AR address.
  input wire burst_master_pkg::len_t arlen, // AR beats minus one.
  input wire logic arvalid, // AR valid.
  output logic arready, // AR ready.
  output burst_master_pkg::id_t rid, // R tag.
  output burst_master_pkg::data_t rdata, // R data.
  output burst_master_pkg::resp_t rresp, // R status.
  output logic rlast, // R last.
  output logic rvalid, // R valid.
  input wire logic rready // R ready.
);
  import burst_master_pkg::*;
  data_t mem [int];
  int aw_a [$];
  id_t aw_i [$];
  id_t b_i [$];
  int ar_a [$];
  int ar_l [$];
  id_t ar_i [$];
  int wb = 0;
  int rb = 0;
  int ph = 0;
  logic go;
  data_t wv;
  // Unwritten words read as their inverted word address.
  function automatic data_t word(int a);
    return mem.exists(a) ? mem[a] : data_t'(~a);
  endfunction
  always @(posedge sys_clk) begin
    if (rst) begin
      {awready, wready, bvalid, arready, rvalid, bid, bresp, rid, rdata, rresp, rlast} <= '0;
      aw_a.delete();
      aw_i.delete();
      b_i.delete();
      ar_a.delete();
      ar_l.delete();
      ar_i.delete();
      wb = 0;
      rb = 0;
    end else begin
      ph = ph + 1;
      if (awvalid && awready) begin
        aw_a.push_back(int'(awaddr >> 2));
        aw_i.push_back(awid);
      end
      if (wvalid && wready) begin
        wv = word(aw_a[0] + wb);
        for (int k = 0; k < 4; k++) if (wstrb[k]) wv[8*k+:8] = wdata[8*k+:8];
        mem[aw_a[0] + wb] = wv;
        wb = wb + 1;
        if (wlast) begin
          b_i.push_back(aw_i.pop_front());
          void'(aw_a.pop_front());
          wb = 0;
        end
      end
      if (bvalid && bready) void'(b_i.pop_front());
      if (arvalid && arready) begin
        ar_a.push_back(int'(araddr >> 2));
        ar_l.push_back(int'(arlen));
        ar_i.push_back(arid);
      end
      if (rvalid && rready) begin
        rb = rb + 1;
        if (rlast) begin
          void'(ar_a.pop_front());
          void'(ar_l.pop_front());
          void'(ar_i.pop_front());
          rb = 0;
        end
      end
      awready <= !ph[0] || !slow;
      wready <= (!ph[0] || !slow) && aw_a.size() > 0;
      arready <= !ph[1] || !slow;
      if (!bvalid || bready) begin
        go = b_i.size() > 0 && (ph[0] || !slow);
        bvalid <= go;
        bid <= go ? b_i[0] : ~bid;
        bresp <= go ? resp_t'(b_i[0]) : ~bresp;
      end
      if (!rvalid || rready) begin
        // a read of another tag may overtake
        if (ooo && rb == 0 && ar_a.size() > 1 && ar_i[$] != ar_i[0]) begin
          ar_a.push_front(ar_a.pop_back());
          ar_l.push_front(ar_l.pop_back());
          ar_i.push_front(ar_i.pop_back());
        end
        go = ar_a.size() > 0 && (ph[1] || !slow);
        rvalid <= go;
        // status and last with each beat
        rid <= go ? ar_i[0] : ~rid;
        rdata <= go ? word(ar_a[0] + rb) : ~rdata;
        rresp <= go ? resp_t'(ar_i[0]) : ~rresp;
        rlast <= go ? rb == ar_l[0] : ~rlast;
      end
    end
  end
endmodule

/* verif/tb_burst_master.sv */
/*
  Self-checking bench for burst_master against the behavioural slave.
  Assumes the design sources and the slave model are compiled first.
*/
`timescale 1ns/10ps
`include "burst_master_regs.svh"
module tb_burst_master;
  import burst_master_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic ooo = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  id_t cmd_id = '0;
  addr_t cmd_addr = '0;
  len_t cmd_len = '0;
  logic ud_valid = 1'b0;
  data_t ud_data = '0;
  logic rd_ready = 1'b0;
  logic wd_ready = 1'b0;
  logic cmd_ready, ud_ready, rd_valid, rd_last, wd_valid, bus_resetn;
  data_t rd_data, wdata, rdata;
  id_t rd_id, wd_id, awid, bid, arid, rid;
  resp_t rd_resp, wd_resp, bresp, rresp;
  addr_t awaddr, araddr;
  len_t awlen, arlen;
  logic [2:0] awsize, arsize;
  logic [1:0] awburst, arburst;
  strb_t wstrb;
  logic awvalid, awready, wlast, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rlast, rvalid, rready;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int n_out = 0;
  logic [15:0] seed = 16'h0559;
  logic [31:0] r;
  logic [31:0] rr;
  data_t emem [int];
  logic [32:0] er [16][$];
  int eb [16];
  logic [36:0] ew [$];
  logic [43:0] ea [$];
  logic [43:0] eg [$];
  data_t ud_q [$];

  burst_master burst_master_inst (.*);
  burst_slave_model burst_slave_model_inst (.*);
  always #2 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, seed ^ 16'h5a5a};
  endfunction

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // The mirror memory is updated at command time, so reads only target
  // words whose writes have completed or that are never written.
  task automatic issue(input logic w, input id_t id, input addr_t a, input len_t l);
    data_t d;
    strb_t s;
    int wa;
    for (int k = 0; k <= l; k++) begin
      wa = int'(a >> 2) + k;
      if (!emem.exists(wa)) emem[wa] = data_t'(~wa);
      if (w) begin
        d = rnd();
        s = (k == 0) ? strb_t'(`STRB_ALL << a[1:0]) : `STRB_ALL;
        ud_q.push_back(d);
        ew.push_back({s, k == l, d});
        for (int j = 0; j < 4; j++) if (s[j]) emem[wa][8*j+:8] = d[8*j+:8];
      end else er[id].push_back({k == l, emem[wa]});
    end
    if (w) eb[id]++;
    if (w) ea.push_back({id, l, a});
    else eg.push_back({id, l, a});
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_id <= id;
    cmd_addr <= a;
    cmd_len <= l;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic drain();
    int n;
    do begin
      @(posedge sys_clk);
      n = ud_q.size() + ew.size() + ea.size() + eg.size();
      for (int i = 0; i < 16; i++) n += er[i].size() + eb[i];
    end while (n != 0);
  endtask

  initial begin
    forever begin
      @(posedge sys_clk);
      if (ud_q.size() > 0) begin
        ud_valid <= 1'b1;
        ud_data <= ud_q[0];
        do @(posedge sys_clk); while (ud_ready !== 1'b1);
        void'(ud_q.pop_front());
        ud_valid <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rr = rnd();
    rd_ready <= !slow || rr[4];
    wd_ready <= !slow || rr[9];
    if (cyc > 2 && cyc < 10) chk(bus_resetn === 1'b0 && cmd_ready === 1'b0, "reset");
    if (cyc == 14) chk(bus_resetn === 1'b1, "bus reset release");
    if (awvalid && awready) begin
      chk({awid, awlen, awaddr} === ea[0] && awsize === `SIZE_FULL, "aw");
      chk(awburst === `BURST_INCR && n_out < int'(`MAX_OUT), "aw limit");
      void'(ea.pop_front());
      n_out++;
    end
    if (bvalid && bready) n_out--;
    if (wvalid && wready) begin
      chk({wstrb, wlast, wdata} === ew[0], "w beat");
      void'(ew.pop_front());
    end
    if (arvalid && arready) begin
      chk({arid, arlen, araddr} === eg[0] && arburst === `BURST_INCR, "ar");
      chk(arsize === `SIZE_FULL, "ar size");
      void'(eg.pop_front());
    end
    if (rd_valid && rd_ready) begin
      chk({rd_last, rd_data} === er[rd_id][0] && rd_resp === resp_t'(rd_id), "rd");
      void'(er[rd_id].pop_front());
    end
    if (wd_valid && wd_ready) begin
      chk(eb[wd_id] > 0 && wd_resp === resp_t'(wd_id), "completion");
      eb[wd_id]--;
    end
  end

  initial begin
    wait (cyc == 20000);
    $display("MISMATCH %0t timeout", $time);
    failures++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
      issue(1'b1, id_t'(i), 32'h0000_0100 + 64 * i + i % 4, len_t'((1 << (i % 4)) - 1));
    drain();
    for (int i = 0; i < 8; i++)
      issue(1'b0, id_t'(i), 32'h0000_0100 + 64 * i, len_t'((1 << (i % 4)) - 1));
    drain();
    slow <= 1'b1;
    ooo <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      if (r[0]) issue(1'b1, id_t'(r[19:16]), 32'h0000_4000 + r[13:2], len_t'(r[22:20]));
      else issue(1'b0, id_t'(i), 32'h0000_8000 + {r[13:4], 2'h0}, len_t'(r[22:20]));
    end
    drain();
    test_done();
  end
endmodule
